//--- dma_gate_pkg.sv
package dma_gate_pkg;
  // ==========================================================================
  // clock figures
  localparam int unsigned main_clk_khz = 100000;
  localparam int unsigned ref_clk_khz = 10000;
  localparam int unsigned mcu_clk_khz = 5000;
  localparam int unsigned timing_clk_khz = 1250;
  localparam int unsigned bit_clk_khz = 1000;
  // half periods in mclk cycles, derived from the rates
  localparam int unsigned mcu_half_cyc = main_clk_khz / (2 * mcu_clk_khz);
  localparam int unsigned timing_half_cyc = main_clk_khz / (2 * timing_clk_khz);
  localparam int unsigned bit_half_cyc = main_clk_khz / (2 * bit_clk_khz);
  localparam int unsigned div_w = 8;
  localparam logic [div_w-1:0] div_zero = 8'h00;
  localparam logic [div_w-1:0] div_one = 8'h01;
  // ==========================================================================
  // address field layout
  localparam int unsigned upper_w = 3;
  localparam logic [upper_w-1:0] upper_reset = 3'h0;
  localparam logic [2:0] sel_dma_cycle = 3'h2; // a15 low, a14 high
  localparam logic [2:0] sel_high_load = 3'h7; // a15..a13 all high
  localparam logic [1:0] sel_dma_mask = 2'h1; // a15 low, a14 high, a13 free
  // collision hold-off after receive activity, in timing clock edges
  localparam logic [3:0] quiet_edges = 4'h8;
  localparam logic [3:0] quiet_zero = 4'h0;
  // ==========================================================================
  // transfer modes: auto, direction, read/write, a13
  typedef enum logic [3:0] {
    mode_mcu_to_link, mode_mcu_to_link_ctl, mode_host_to_mcu, mode_mcu_to_host,
    mode_link_to_mcu, mode_link_stat_to_mcu, mode_host_to_link, mode_link_to_host,
    mode_none
  } xfer_mode_t;
endpackage

//--- edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser with rise/fall pulses taken from the second stage
module edge_sync
  import dma_gate_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // raw input and results
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // ==========================================================================
  // synchroniser; meta_q feeds sync_q only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule
`default_nettype wire

//--- dma_gate_array.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - drive 5 MHz mcu clock; in link data modes, freeze after cycle start until service request.
// - time internal events from returned 1.25 MHz clock, which stops when frozen.
// - drive free 1.25 MHz timing clock to link controller, never frozen.
// - drive 1 MHz bit clock; resync on each receive line transition while line enable is low.
// - receive activity triggers collision avoidance and bit clock resync.
// - request-to-send edge raises line enable, or interrupt if collision.
// - pull shared open-collector interrupt low on collision avoidance.
// - assert active-low chip select on mcu link controller register accesses.
// - sample a15..a13 on strobe fall; 01x starts cycle-active.
// - sampled 111 produces the high-address load pulse.
// - load pulse latches data bits 2..0 as address bits 15..13.
// - host modes add a13 carry to the 3-bit register.
// - non-host modes use a13 to pick register or fifo access.
// - output carry out of the 15..13 addition, active high.
// - active-low reset returns all internal logic to initial state.
// - command strobe produces out-latch clock capturing command vector byte.
// - ready status high while command register can accept a byte.
// - cycle-active marks dma cycle and stays high while mcu frozen.
// - active-low gate puts host-to-transporter latch on mcu bus in cycles.
// - out-latch clock follows strobe or grant when direction low.
// - select source and destination from auto, direction, rw and a13.
// - raise transfer request; on grant issue latch clock or gate.
// - in-latch gate follows grant when direction high.
module dma_gate_array
  import dma_gate_pkg::*;
#(
  parameter int unsigned mcu_half = mcu_half_cyc,
  parameter int unsigned timing_half = timing_half_cyc,
  parameter int unsigned bit_half = bit_half_cyc
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // microcontroller side
  input wire logic mcu_eclock_return,
  input wire logic mcu_address_strobe,
  input wire logic [2:0] mcu_addr_hi,
  input wire logic [2:0] mcu_data_lo,
  input wire logic auto_mode,
  input wire logic dir_in,
  input wire logic mcu_rw,
  output logic mcu_clock_out,
  output logic irq_o,
  output logic irq_oe,
  // link controller side
  input wire logic tx_service_request,
  input wire logic rx_service_request,
  input wire logic link_rts,
  input wire logic serial_rx,
  output logic link_timing_clock,
  output logic serial_bit_clock,
  output logic line_driver_enable,
  output logic link_cs_n,
  // address outputs
  output logic cycle_active_latch,
  output logic high_addr_load,
  output logic [upper_w-1:0] dma_addr_upper,
  output logic upper_addr_carry_out,
  output logic [3:0] xfer_mode,
  // host side
  input wire logic host_strobe_n,
  input wire logic host_transfer_grant_n,
  output logic command_ready,
  output logic host_transfer_request,
  output logic host_out_latch_clock_n,
  output logic host_out_latch_gate_n,
  output logic host_in_latch_gate_n
);
  // ==========================================================================
  // synchronised inputs
  logic ecl_rise, as_fall, rts_rise, rx_rise, rx_fall, rts_lvl;
  logic tx_service_request_lvl, rx_service_request_lvl, strb_fall, strb_on, grant_lvl;
  logic [8:0] pin_meta_q, pin_q;
  logic [2:0] ahi_q, data_s;
  logic auto_s, dir_s, rw_s;

  // returned clock edges time internal events
  edge_sync u_ecl (.mclk(mclk), .rst_n(rst_n), .async_in(mcu_eclock_return),
    .level(), .rise(ecl_rise), .fall());
  edge_sync u_as (.mclk(mclk), .rst_n(rst_n), .async_in(mcu_address_strobe),
    .level(), .rise(), .fall(as_fall));
  edge_sync u_rts (.mclk(mclk), .rst_n(rst_n), .async_in(link_rts),
    .level(rts_lvl), .rise(rts_rise), .fall());
  edge_sync u_rx (.mclk(mclk), .rst_n(rst_n), .async_in(serial_rx),
    .level(), .rise(rx_rise), .fall(rx_fall));
  // service requests are active high levels from the link controller
  edge_sync u_tx_service_request (.mclk(mclk), .rst_n(rst_n), .async_in(tx_service_request),
    .level(tx_service_request_lvl), .rise(), .fall());
  edge_sync u_rx_service_request (.mclk(mclk), .rst_n(rst_n), .async_in(rx_service_request),
    .level(rx_service_request_lvl), .rise(), .fall());
  // strobe inverted on the way in, so the flops' reset level means idle, not asserted
  edge_sync u_strb (.mclk(mclk), .rst_n(rst_n), .async_in(~host_strobe_n),
    .level(strb_on), .rise(strb_fall), .fall());
  edge_sync u_gnt (.mclk(mclk), .rst_n(rst_n), .async_in(~host_transfer_grant_n),
    .level(grant_lvl), .rise(), .fall());

  // address, data and mode pins share one two-stage path, so they stay aligned with the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 9'h000;
      pin_q <= 9'h000;
    end else begin
      pin_meta_q <= {auto_mode, dir_in, mcu_rw, mcu_data_lo, mcu_addr_hi};
      pin_q <= pin_meta_q;
    end
  end
  assign {auto_s, dir_s, rw_s, data_s, ahi_q} = pin_q;

  // ==========================================================================
  // clock dividers from mclk (reference stands in for the 10 MHz input)
  // the main clock rate fixes the divider ratios
  logic [div_w-1:0] mdiv_q, tdiv_q, bdiv_q;
  logic mclk_o_q, tclk_q, bclk_q, frozen_q;
  logic [div_w-1:0] mcu_lim, tim_lim, bit_lim;
  logic bit_resync;
  assign mcu_lim = div_w'(mcu_half - 1);
  assign tim_lim = div_w'(timing_half - 1);
  assign bit_lim = div_w'(bit_half - 1);
  assign bit_resync = rx_rise | rx_fall;

  // mcu clock stops in its low phase while frozen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mdiv_q <= div_zero;
      mclk_o_q <= 1'b0;
    end else if (frozen_q && !mclk_o_q) begin
      mdiv_q <= div_zero;
    end else if (mdiv_q == mcu_lim) begin
      mdiv_q <= div_zero;
      mclk_o_q <= ~mclk_o_q;
    end else begin
      mdiv_q <= mdiv_q + div_one;
    end
  end

  // timing clock never looks at the freeze
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tdiv_q <= div_zero;
      tclk_q <= 1'b0;
    end else if (tdiv_q == tim_lim) begin
      tdiv_q <= div_zero;
      tclk_q <= ~tclk_q;
    end else begin
      tdiv_q <= tdiv_q + div_one;
    end
  end

  // free running, restarted mid-bit on every receive line transition while the line driver is off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bdiv_q <= div_zero;
      bclk_q <= 1'b0;
    end else if (bit_resync && !line_driver_enable) begin
      bdiv_q <= div_zero;
      bclk_q <= 1'b0;
    end else if (bdiv_q == bit_lim) begin
      bdiv_q <= div_zero;
      bclk_q <= ~bclk_q;
    end else begin
      bdiv_q <= bdiv_q + div_one;
    end
  end

  assign mcu_clock_out = mclk_o_q;
  assign link_timing_clock = tclk_q;
  assign serial_bit_clock = bclk_q;

  // ==========================================================================
  // address strobe decode
  logic dma_hit, hi_hit;
  assign dma_hit = as_fall && (ahi_q[2:1] == sel_dma_mask);
  assign hi_hit = as_fall && (ahi_q == sel_high_load);

  // mode selection from auto, direction, rw, a13
  function automatic xfer_mode_t decode_mode(input logic au, input logic io,
                                              input logic rw, input logic a13);
    xfer_mode_t m;
    m = mode_none;
    if (!au && !io && !rw) m = a13 ? mode_mcu_to_link_ctl : mode_mcu_to_link;
    else if (!au && !io && rw) m = mode_host_to_mcu;
    else if (!au && io && !rw) m = mode_mcu_to_host;
    else if (!au && io && rw) m = a13 ? mode_link_stat_to_mcu : mode_link_to_mcu;
    else if (au && !io && rw) m = mode_host_to_link;
    else if (au && io && rw) m = mode_link_to_host;
    return m;
  endfunction

  xfer_mode_t mode_q, mode_now;
  logic a13_q;
  assign mode_now = decode_mode(auto_s, dir_s, rw_s, ahi_q[0]);

  logic host_mode, link_data_mode, link_reg_mode;
  assign host_mode = (mode_q == mode_host_to_mcu) || (mode_q == mode_mcu_to_host) ||
                     (mode_q == mode_host_to_link) || (mode_q == mode_link_to_host);
  // a13 picks control/status registers over data fifos
  assign link_reg_mode = (mode_q == mode_mcu_to_link_ctl) ||
                         (mode_q == mode_link_stat_to_mcu);
  assign link_data_mode = (mode_q == mode_mcu_to_link) || (mode_q == mode_link_to_mcu) ||
                          (mode_q == mode_host_to_link) || (mode_q == mode_link_to_host);

  // ==========================================================================
  // cycle state machine
  typedef enum logic [1:0] {st_idle, st_arm, st_frozen, st_finish} cyc_state_t;
  cyc_state_t st_q, st_d;
  logic service;
  assign service = tx_service_request_lvl | rx_service_request_lvl;

  // freeze only when link data is serialised; else run straight to finish
  always_comb begin
    st_d = st_q;
    case (st_q)
      st_idle: if (dma_hit) st_d = st_arm;
      st_arm: if (ecl_rise) st_d = link_data_mode ? st_frozen : st_finish;
      st_frozen: if (service) st_d = st_finish;
      st_finish: if (ecl_rise) st_d = st_idle;
      default: st_d = st_idle;
    endcase
  end

  // every state element resets: st_q to st_idle, a13_q to 0, mode_q to mode_none
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= st_idle;
      mode_q <= mode_none;
      a13_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (dma_hit) begin
        mode_q <= mode_now;
        a13_q <= ahi_q[0];
      end
    end
  end

  // cycle-active raised by the strobe decode
  // dropped at the returned clock rise after restart
  assign cycle_active_latch = (st_q != st_idle);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) frozen_q <= 1'b0;
    else frozen_q <= (st_d == st_frozen);
  end
  assign xfer_mode = 4'(mode_q);

  // ==========================================================================
  // upper address register and adder
  logic [upper_w-1:0] upper_q;
  logic hl_q;
  logic [upper_w:0] upper_sum;
  // data bits 2..0 become address bits 15..13
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upper_q <= upper_reset;
      hl_q <= 1'b0;
    end else begin
      hl_q <= hi_hit;
      if (hi_hit) upper_q <= data_s;
    end
  end
  assign high_addr_load = hl_q;
  // carry from the low 13 bits added in host modes
  // carry out of the 3-bit addition
  assign upper_sum = {1'b0, upper_q} + {{upper_w{1'b0}}, (host_mode & a13_q)};
  assign dma_addr_upper = upper_sum[upper_w-1:0];
  assign upper_addr_carry_out = upper_sum[upper_w];

  // chip select while mcu touches link controller registers or fifos
  assign link_cs_n = ~(cycle_active_latch & (link_reg_mode | link_data_mode));

  // ==========================================================================
  // collision avoidance and transmit enable
  logic [3:0] quiet_q;
  logic txen_q, irq_q, busy;
  assign busy = (quiet_q != quiet_zero);
  // receive activity re-arms the quiet window
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) quiet_q <= quiet_zero;
    else if (bit_resync) quiet_q <= quiet_edges;
    else if (tclk_q && tdiv_q == div_zero && busy) quiet_q <= quiet_q - 4'h1;
  end
  // rts edge chooses enable or interrupt
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txen_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (rts_rise) begin
      txen_q <= ~busy;
      irq_q <= busy;
    end else if (!rts_lvl) begin
      txen_q <= 1'b0;
      irq_q <= 1'b0;
    end
  end
  assign line_driver_enable = txen_q;
  assign irq_o = 1'b0;
  assign irq_oe = irq_q;

  // ==========================================================================
  // host handshakes
  logic cmd_full_q, req_q;
  // ready drops until the mcu gates it out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cmd_full_q <= 1'b0;
    else if (strb_fall) cmd_full_q <= 1'b1;
    else if (st_q == st_finish && mode_q == mode_host_to_mcu) cmd_full_q <= 1'b0;
  end
  assign command_ready = ~cmd_full_q;

  // request held until the grant arrives
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) req_q <= 1'b0;
    else if (dma_hit && (mode_now == mode_host_to_mcu || mode_now == mode_mcu_to_host ||
             mode_now == mode_host_to_link || mode_now == mode_link_to_host))
      req_q <= 1'b1;
    else if (grant_lvl) req_q <= 1'b0;
  end
  assign host_transfer_request = req_q;

  // out-latch clock follows strobe or grant with direction low
  assign host_out_latch_clock_n = ~(~dir_s & (strb_on | (grant_lvl & host_mode)));
  // in-latch gate follows grant with direction high
  assign host_in_latch_gate_n = ~(dir_s & grant_lvl & host_mode);
  // out-latch contents onto mcu bus during cycles
  assign host_out_latch_gate_n = ~(cycle_active_latch & (mode_q == mode_host_to_mcu));

  // ==========================================================================
  // checks
  // hit starts cycle
  a_cycle_start: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == st_idle && dma_hit) |=> cycle_active_latch) else $error("no cycle start");
  a_freeze_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    frozen_q |-> cycle_active_latch) else $error("frozen without cycle");
  a_freeze_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    (frozen_q && $past(frozen_q) && !mclk_o_q) |=> !mclk_o_q) else $error("clock ran");
  a_load_data: assert property (@(posedge mclk) disable iff (!rst_n)
    hi_hit |=> (upper_q == $past(data_s)) && high_addr_load) else $error("bad load");
  a_carry_sum: assert property (@(posedge mclk) disable iff (!rst_n)
    (host_mode && a13_q && upper_q == 3'h7) |-> upper_addr_carry_out) else $error("carry");
  a_rts_choice: assert property (@(posedge mclk) disable iff (!rst_n)
    (rts_rise && !busy) |=> line_driver_enable && !irq_oe) else $error("no enable");
  a_collide_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    (rts_rise && busy) |=> irq_oe && !line_driver_enable) else $error("no irq");
  a_cmd_ready: assert property (@(posedge mclk) disable iff (!rst_n)
    strb_fall |=> !command_ready) else $error("ready stayed high");
  a_timing_free: assert property (@(posedge mclk) disable iff (!rst_n)
    (tdiv_q == tim_lim) |=> (link_timing_clock != $past(link_timing_clock)))
    else $error("timing clock stalled");
  c_dma_cycle: cover property (@(posedge mclk) disable iff (!rst_n) frozen_q ##1 !frozen_q);
  c_high_load: cover property (@(posedge mclk) disable iff (!rst_n) high_addr_load);
  c_collision: cover property (@(posedge mclk) disable iff (!rst_n) irq_oe);
  c_host_grant: cover property (@(posedge mclk) disable iff (!rst_n) req_q ##1 grant_lvl);
endmodule
`default_nettype wire

//--- mcu_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// microcontroller clock return and link controller service requests
module mcu_link_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // from the block
  input wire logic mcu_clock_out,
  input wire logic cycle_active_latch,
  // bench controls: which request answers, and how late
  input wire logic svc_rx,
  input wire logic [9:0] svc_wait,
  // to the block
  output logic mcu_eclock_return,
  output logic tx_service_request,
  output logic rx_service_request
);
  logic mco_q;
  logic [1:0] div_q;
  logic [9:0] wait_q;
  logic due_d;
  // returned clock freezes
  // divide by four on mcu clock rises, so a frozen mcu clock stops it too
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mco_q <= 1'b0;
      div_q <= 2'h0;
    end else begin
      mco_q <= mcu_clock_out;
      if (mcu_clock_out && !mco_q) begin
        div_q <= div_q + 2'h1;
      end
    end
  end
  assign mcu_eclock_return = div_q[1];
  // service requests high
  // a slow fifo: the request comes svc_wait cycles in and drops when the cycle ends
  assign due_d = cycle_active_latch && (wait_q == svc_wait);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 10'h000;
      tx_service_request <= 1'b0;
      rx_service_request <= 1'b0;
    end else if (!cycle_active_latch) begin
      wait_q <= 10'h000;
      tx_service_request <= 1'b0;
      rx_service_request <= 1'b0;
    end else begin
      if (!due_d) begin
        wait_q <= wait_q + 10'h001;
      end
      tx_service_request <= tx_service_request | (due_d & !svc_rx);
      rx_service_request <= rx_service_request | (due_d & svc_rx);
    end
  end
endmodule
`default_nettype wire

//--- dma_gate_array_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// self-checking bench for the dma gate array
module dma_gate_array_tb_top
  import dma_gate_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, mcu_address_strobe = 1'b1;
  logic [2:0] mcu_addr_hi = 3'h0, mcu_data_lo = 3'h0;
  logic auto_mode = 1'b0, dir_in = 1'b0, mcu_rw = 1'b0, link_rts = 1'b0, serial_rx = 1'b0;
  logic host_strobe_n = 1'b1, host_transfer_grant_n = 1'b1, svc_rx = 1'b0;
  logic [9:0] svc_wait = 10'd300;
  logic mcu_eclock_return, tx_service_request, rx_service_request, mcu_clock_out, irq_o, irq_oe;
  logic link_timing_clock, serial_bit_clock, line_driver_enable, link_cs_n, cycle_active_latch;
  logic high_addr_load, upper_addr_carry_out, command_ready, host_transfer_request;
  logic host_out_latch_clock_n, host_out_latch_gate_n, host_in_latch_gate_n, irq_line_n;
  logic [2:0] dma_addr_upper;
  logic [3:0] xfer_mode, em;
  logic mc_p = 1'b0, tc_p = 1'b0, bc_p = 1'b0, frz, hst;
  logic [7:0] hl, cas;
  int err_total = 0, checks_done = 0, mc_n = 0, tc_n = 0, bc_n = 0, cyc = 0;
  int k, c, a, n0, n1, n2, t0;
  // open-drain interrupt wire, pulled up when nobody pulls low
  assign irq_line_n = irq_oe ? irq_o : 1'b1;
  dma_gate_array i_dma_gate_array (.mclk, .rst_n, .mcu_eclock_return, .mcu_address_strobe,
    .mcu_addr_hi, .mcu_data_lo, .auto_mode, .dir_in, .mcu_rw, .mcu_clock_out, .irq_o, .irq_oe,
    .tx_service_request, .rx_service_request, .link_rts, .serial_rx, .link_timing_clock,
    .serial_bit_clock, .line_driver_enable, .link_cs_n, .cycle_active_latch, .high_addr_load,
    .dma_addr_upper, .upper_addr_carry_out, .xfer_mode, .host_strobe_n, .host_transfer_grant_n,
    .command_ready, .host_transfer_request, .host_out_latch_clock_n, .host_out_latch_gate_n,
    .host_in_latch_gate_n);
  mcu_link_model i_mcu_link_model (.mclk, .rst_n, .mcu_clock_out, .cycle_active_latch, .svc_rx,
    .svc_wait, .mcu_eclock_return, .tx_service_request, .rx_service_request);
  always #5 mclk = ~mclk;
  // rise counters for the output clocks, and the hang limit
  always @(posedge mclk) begin
    mc_p <= mcu_clock_out;
    tc_p <= link_timing_clock;
    bc_p <= serial_bit_clock;
    if (mcu_clock_out && !mc_p) mc_n++;
    if (link_timing_clock && !tc_p) tc_n++;
    if (serial_bit_clock && !bc_p) bc_n++;
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ca(input logic lvl, input int lim);
    k = 0;
    while (k < lim && cycle_active_latch !== lvl) begin
      @(negedge mclk);
      k++;
    end
  endtask
  // strobe falls with a15..a13 and the auto, direction and rw levels
  task automatic strobe_fall(input logic [2:0] adr, input logic [2:0] m);
    @(posedge mclk);
    {auto_mode, dir_in, mcu_rw} <= m;
    mcu_addr_hi <= adr;
    mcu_address_strobe <= 1'b0;
  endtask
  task automatic strobe_up();
    @(posedge mclk);
    mcu_address_strobe <= 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  // mode chart, keyed by {auto, direction, rw, a13}
  function automatic logic [3:0] exp_mode(input logic [3:0] m);
    casez (m)
      4'b0000: return mode_mcu_to_link;
      4'b0001: return mode_mcu_to_link_ctl;
      4'b001?: return mode_host_to_mcu;
      4'b010?: return mode_mcu_to_host;
      4'b0110: return mode_link_to_mcu;
      4'b0111: return mode_link_stat_to_mcu;
      4'b101?: return mode_host_to_link;
      4'b111?: return mode_link_to_host;
      default: return mode_none;
    endcase
  endfunction
  initial begin
    repeat (2) @(negedge mclk);
    check({cycle_active_latch, line_driver_enable, irq_oe, host_transfer_request}, 8'h00);
    check({mcu_clock_out, high_addr_load, command_ready, dma_addr_upper}, 8'h08);
    check({link_cs_n, host_out_latch_clock_n, host_out_latch_gate_n, host_in_latch_gate_n}, 8'h0f);
    @(posedge mclk) rst_n <= 1'b1;
    repeat (4) @(negedge mclk);
    n0 = mc_n;
    n1 = tc_n;
    n2 = bc_n;
    repeat (800) @(negedge mclk);
    check(8'(mc_n - n0), 8'd40);
    check(8'(tc_n - n1), 8'd10);
    check(8'(bc_n - n2), 8'd8);
    $display("test clock rates done");
    // a15 high, a15 and a14 low, then an upper address load of 7
    @(posedge mclk) mcu_data_lo <= 3'h7;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 6 : ((i == 1) ? 1 : 7);
      strobe_fall(3'(a), 3'h0);
      hl = 8'h00;
      cas = 8'h00;
      repeat (10) begin
        @(negedge mclk);
        hl += high_addr_load;
        cas += cycle_active_latch;
      end
      check(hl, (a == 7) ? 8'h01 : 8'h00);
      check(cas, 8'h00);
      strobe_up();
    end
    $display("test upper load done");
    @(posedge mclk) host_strobe_n <= 1'b0;
    repeat (5) @(negedge mclk);
    check({command_ready, host_out_latch_clock_n}, 8'h00);
    @(posedge mclk) host_strobe_n <= 1'b1;
    repeat (5) @(negedge mclk);
    check({command_ready, host_out_latch_clock_n}, 8'h01);
    $display("test command strobe done");
    for (c = 0; c < 16; c++) begin
      em = exp_mode(4'(c));
      frz = em inside {mode_mcu_to_link, mode_link_to_mcu, mode_host_to_link, mode_link_to_host};
      hst = em inside {mode_host_to_mcu, mode_mcu_to_host, mode_host_to_link, mode_link_to_host};
      svc_rx <= em inside {mode_link_to_mcu, mode_link_to_host};
      strobe_fall({2'b01, c[0]}, c[3:1]);
      wait_ca(1'b1, 10);
      t0 = cyc;
      check(cycle_active_latch, 1'b1);
      check(xfer_mode, em);
      if (hst) check({upper_addr_carry_out, dma_addr_upper}, 4'h7 + 4'(c[0]));
      if (em inside {mode_mcu_to_link_ctl, mode_link_stat_to_mcu}) check(link_cs_n, 1'b0);
      if (em inside {mode_host_to_mcu, mode_mcu_to_host}) check(link_cs_n, 1'b1);
      if (em == mode_host_to_mcu) check(host_out_latch_gate_n, 1'b0);
      if (hst) begin
        for (k = 0; k < 20 && host_transfer_request !== 1'b1; k++) @(negedge mclk);
        check(host_transfer_request, 1'b1);
        @(posedge mclk) host_transfer_grant_n <= 1'b0;
        repeat (5) @(negedge mclk);
        check({host_transfer_request, host_out_latch_clock_n, host_in_latch_gate_n},
          {5'h0, 1'b0, c[2], !c[2]});
        @(posedge mclk) host_transfer_grant_n <= 1'b1;
      end
      strobe_up();
      if (frz) begin
        n1 = tc_n;
        repeat (150) @(negedge mclk);
        check({cycle_active_latch, mcu_clock_out}, 8'h02);
        check(tc_n > n1, 1'b1);
      end
      wait_ca(1'b0, 600);
      check(frz ? (cyc - t0 > 300 && cyc - t0 < 400) : (cyc - t0 < 170), 1'b1);
      repeat (5) @(negedge mclk);
    end
    check(command_ready, 1'b1);
    $display("test transfer modes done");
    @(posedge mclk) link_rts <= 1'b1;
    repeat (5) @(negedge mclk);
    check({line_driver_enable, irq_line_n}, 8'h03);
    @(posedge mclk) link_rts <= 1'b0;
    repeat (5) @(negedge mclk);
    check({line_driver_enable, irq_line_n}, 8'h01);
    n2 = bc_n;
    for (k = 0; k < 200 && bc_n == n2; k++) @(negedge mclk);
    @(posedge mclk) serial_rx <= ~serial_rx;
    repeat (5) @(negedge mclk);
    check(serial_bit_clock, 1'b0);
    @(posedge mclk) link_rts <= 1'b1;
    repeat (5) @(negedge mclk);
    check({line_driver_enable, irq_line_n}, 8'h00);
    @(posedge mclk) link_rts <= 1'b0;
    repeat (5) @(negedge mclk);
    check({line_driver_enable, irq_line_n}, 8'h01);
    $display("test collision done");
    give_verdict();
  end
endmodule
`default_nettype wire
